// File: src/dioc_cfg.svh
// constants of the digital i/o and counter block
`ifndef DIOC_CFG_SVH
`define DIOC_CFG_SVH
`define DIOC_CLK_MHZ 125
`define DIOC_FILT_UNIT_US 100
`define DIOC_SAMPLE_UNITS 8'd2
`define DIOC_FILT_MAX 8'd250
`define DIOC_OFS_INPUT 16'h0000
`define DIOC_OFS_OUTPUT 16'h0002
`define DIOC_OFS_CNT1 16'h0004
`define DIOC_OFS_CNT2 16'h0006
`define DIOC_OFS_DIR 16'h0010
`define DIOC_OFS_FILT 16'h0012
`define DIOC_OFS_CCFG1 16'h0014
`define DIOC_OFS_CCFG2 16'h0016
`define DIOC_OFS_LATCH 16'h001a
`define DIOC_OFS_ACK 16'h001c
`define DIOC_OFS_FAULT 16'h001e
`define DIOC_OFS_MODID 16'h2000
`define DIOC_OFS_SUPST 16'h2004
`define DIOC_OFS_SUPIN 16'h2010
`define DIOC_CAN_POS_INPUT 0
`define DIOC_CAN_POS_OUTPUT 0
`define DIOC_RST_DIR 8'h00
`define DIOC_RST_FILT 8'h00
`define DIOC_RST_CCFG 8'h00
`define DIOC_CCFG_TB_LSB 0
`define DIOC_CCFG_CLR_BIT 5
`define DIOC_CCFG_MODE_LSB 6
`define DIOC_COUNTER_PINS 8'h0f
`define DIOC_SUPPLY_LO 8'd18
`define DIOC_SUPPLY_HI 8'd30
`define DIOC_TB_MOD 16'd2000
`define DIOC_TB_STEP_48M 16'd768
`define DIOC_TB_STEP_3M 16'd48
`define DIOC_TB_STEP_187K 16'd3
`endif

// File: src/dioc_pkg.sv
// types of the digital i/o and counter block
package dioc_pkg;
  typedef enum logic [1:0] {
    DIOC_MODE_EVENT,
    DIOC_MODE_GATE,
    DIOC_MODE_RSV2,
    DIOC_MODE_RSV3
  } dioc_mode_t;
  typedef enum logic [2:0] {
    DIOC_TB_48M,
    DIOC_TB_3M,
    DIOC_TB_187K,
    DIOC_TB_RSV3,
    DIOC_TB_RSV4,
    DIOC_TB_RSV5,
    DIOC_TB_RSV6,
    DIOC_TB_RSV7
  } dioc_tb_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dioc_req_t;
  typedef struct packed {
    logic [1:0] mode;
    logic clr;
    logic [1:0] rsv;
    logic [2:0] tb;
  } dioc_ccfg_t;
endpackage

// File: src/dioc_tick.sv
// filter tick divider and gate timebase enables
`timescale 1ns/1ns
`include "dioc_cfg.svh"
module dioc_tick
  import dioc_pkg::*;
#(
  parameter int TICK_CYCLES = `DIOC_FILT_UNIT_US * `DIOC_CLK_MHZ
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic tick_out,
  output logic [2:0] tb_out
);
  localparam logic [15:0] STEPS [3] = '{`DIOC_TB_STEP_48M,
    `DIOC_TB_STEP_3M, `DIOC_TB_STEP_187K};
  logic [15:0] div_q;
  logic [15:0] acc_q [3];
  wire div_end = (div_q == 16'(TICK_CYCLES - 1));
  assign tick_out = div_end;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) div_q <= 16'h0000;
    else div_q <= div_end ? 16'h0000 : div_q + 16'h0001;
  end

  // phase accumulators give exact average rates from the 125 MHz clock
  for (genvar k = 0; k < 3; k++) begin : g_tb
    wire [15:0] nxt = acc_q[k] + STEPS[k];
    wire wrap = (nxt >= `DIOC_TB_MOD);
    assign tb_out[k] = wrap;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) acc_q[k] <= 16'h0000;
      else acc_q[k] <= wrap ? nxt - `DIOC_TB_MOD : nxt;
    end
  end

  chk_tick_period: assert property (@(posedge clk_in) // [R4]
    disable iff (!rst_n_in) tick_out |=> !tick_out)
    else $error("filter tick not a single pulse");
endmodule // dioc_tick

// File: src/dioc_counter.sv
// one counter channel: event count or gate time
`timescale 1ns/1ns
`include "dioc_cfg.svh"
module dioc_counter
  import dioc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic sig_in,
  input wire dioc_ccfg_t cfg_in,
  input wire logic [2:0] tb_in,
  output logic [15:0] value_out
);
  logic sig_q;
  logic [15:0] run_q;
  wire rise = sig_in & ~sig_q;
  wire fall = ~sig_in & sig_q;
  wire gate_mode = (cfg_in.mode == DIOC_MODE_GATE); // [R10]
  wire hold_zero = cfg_in.clr | ~enable_in; // [R9] [R15]
  // reserved timebase codes leave the gate counter still
  wire tb_tick = (cfg_in.tb == DIOC_TB_48M) ? tb_in[0] :
                 (cfg_in.tb == DIOC_TB_3M) ? tb_in[1] :
                 (cfg_in.tb == DIOC_TB_187K) ? tb_in[2] : 1'b0; // [R8]

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) sig_q <= 1'b0;
    else sig_q <= sig_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_q <= 16'h0000;
      value_out <= 16'h0000;
    end else if (hold_zero) begin
      run_q <= 16'h0000;
      value_out <= 16'h0000;
    end else if (!gate_mode) begin
      if (rise) value_out <= value_out + 16'h0001; // [R14]
    end else begin
      if (rise) run_q <= 16'h0000;
      else if (sig_in && tb_tick) run_q <= run_q + 16'h0001;
      if (fall) value_out <= run_q; // [R14]
    end
  end

  chk_clear_hold: assert property (@(posedge clk_in) // [R15]
    disable iff (!rst_n_in) cfg_in.clr |=> value_out == 16'h0000)
    else $error("counter not held by clear bit");
  chk_event_step: assert property (@(posedge clk_in) // [R10]
    disable iff (!rst_n_in)
    (!hold_zero && !gate_mode && rise) |=>
      value_out == $past(value_out) + 16'h0001)
    else $error("event counter missed an edge");
endmodule // dioc_counter

// File: src/dioc_top.sv
// eight-channel digital i/o with two counters and register port
// Summary of operation
// R1: mask bit 0 input, 1 output, reset 0
// R2: outputs monitored and unfiltered; inputs filtered
// R3: counter operation forces channels 1-4 input
// R4: one filter value, 100 us per unit
// R5: pins sampled every 200 us
// R6: filter value 0 disables filtering, reset 0
// R7: filter values above 250 clamp to 250
// R8: timebase bits 0-2: 48M, 3M, 187.5k
// R9: clear bit 5 set clears the counter
// R10: mode bits 6-7: 0 events, 1 gate
// R11: input and output bytes at position 0
// R12: rising edges latched; acknowledge clears and blocks
// R13: output fault bit on commanded/actual mismatch
// R14: 16-bit counter value, event or gate time
// R15: counter held zero while clear bit set
`timescale 1ns/1ns
`include "dioc_cfg.svh"
module dioc_top
  import dioc_pkg::*;
#(
  parameter int TICK_CYCLES = `DIOC_FILT_UNIT_US * `DIOC_CLK_MHZ,
  // arbitrary neutral identifier value
  parameter logic [15:0] MODULE_ID = 16'h0001
) (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic COUNTER_OP_IN,
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE_OUT,
  input wire logic [7:0] SUPPLY_VOLT_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [15:0] REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  output logic [15:0] REG_RDATA_OUT,
  output logic REG_ACK_OUT
);
  logic [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  dioc_req_t req;
  assign req = '{wr: REG_WR_IN, rd: REG_RD_IN, addr: REG_ADDR_IN,
                 wdata: REG_WDATA_IN};

  // configuration and command registers
  logic [7:0] dir_q;
  logic [7:0] filt_q;
  dioc_ccfg_t ccfg_q [2];
  logic [7:0] out_q;
  logic [7:0] ack_q;

  function automatic logic hit(input dioc_req_t r, input logic [15:0] a);
    return r.wr && (r.addr == a);
  endfunction

  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= `DIOC_RST_DIR; // [R1]
      filt_q <= `DIOC_RST_FILT; // [R6]
      ccfg_q[0] <= `DIOC_RST_CCFG;
      ccfg_q[1] <= `DIOC_RST_CCFG;
      out_q <= 8'h00;
      ack_q <= 8'h00;
    end else begin
      if (hit(req, `DIOC_OFS_DIR)) dir_q <= req.wdata[7:0];
      if (hit(req, `DIOC_OFS_FILT)) filt_q <= req.wdata[7:0];
      if (hit(req, `DIOC_OFS_CCFG1)) ccfg_q[0] <= req.wdata[7:0];
      if (hit(req, `DIOC_OFS_CCFG2)) ccfg_q[1] <= req.wdata[7:0];
      if (hit(req, `DIOC_OFS_OUTPUT)) out_q <= req.wdata[7:0];
      if (hit(req, `DIOC_OFS_ACK)) ack_q <= req.wdata[7:0];
    end
  end

  // counter operation overrides the mask on the counter pins
  wire [7:0] lock = COUNTER_OP_IN ? `DIOC_COUNTER_PINS : 8'h00; // [R3]
  wire [7:0] dir_eff = dir_q & ~lock; // [R1] [R3]
  wire [7:0] filt_eff = (filt_q > `DIOC_FILT_MAX) ?
                        `DIOC_FILT_MAX : filt_q; // [R7]

  // pin drivers
  logic [7:0] pin_out_q;
  logic [7:0] pin_oe_q;
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_q <= 8'h00;
      pin_oe_q <= 8'h00;
    end else begin
      pin_out_q <= out_q & dir_eff;
      pin_oe_q <= dir_eff; // [R1]
    end
  end
  assign PIN_OUT = pin_out_q;
  assign PIN_OE_OUT = pin_oe_q;

  // three-stage pin synchroniser, change taken when stages 2 and 3 agree
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;
  logic [7:0] pin_q;
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
      pin_q <= 8'h00;
    end else begin
      s1_q <= PIN_IN;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 8; i++) begin
        if (s2_q[i] == s3_q[i]) pin_q[i] <= s3_q[i];
      end
    end
  end

  // sample grid: every second 100 us tick
  logic tick;
  logic [2:0] tb;
  logic half_q;
  dioc_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_in(REF_CLK_IN),
    .rst_n_in(rst_n),
    .tick_out(tick),
    .tb_out(tb)
  );
  wire sample = tick & half_q; // [R5]
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) half_q <= 1'b0;
    else if (tick) half_q <= ~half_q;
  end

  // gap counter lets the grid check see the exact spacing
  logic [15:0] gap_q;
  logic seen_q;
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      gap_q <= sample ? 16'h0000 : gap_q + 16'h0001;
      seen_q <= seen_q | sample;
    end
  end

  // filter, input state, latches and fault status
  logic [7:0] state_q;
  logic [7:0] fcnt_q [8];
  logic [7:0] latch_q;
  logic [7:0] fault_q;
  logic [7:0] state_d;
  wire [7:0] rise = state_d & ~state_q;

  always_comb begin
    state_d = state_q;
    if (sample) begin
      for (int i = 0; i < 8; i++) begin
        // outputs skip the filter so readback is the live pin
        if (dir_eff[i] || filt_eff == 8'h00) state_d[i] = pin_q[i]; // [R2]
        else if (pin_q[i] != state_q[i] &&
                 fcnt_q[i] + `DIOC_SAMPLE_UNITS >= filt_eff)
          state_d[i] = pin_q[i]; // [R4]
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= 8'h00;
      fault_q <= 8'h00;
      for (int i = 0; i < 8; i++) fcnt_q[i] <= 8'h00;
    end else begin
      state_q <= state_d;
      if (sample) begin
        // coarse 200 us grid: odd filter values round up
        for (int i = 0; i < 8; i++) begin
          if (pin_q[i] == state_d[i]) fcnt_q[i] <= 8'h00;
          else fcnt_q[i] <= fcnt_q[i] + `DIOC_SAMPLE_UNITS; // [R4] [R5]
        end
        fault_q <= dir_eff & (pin_q ^ out_q); // [R13] [R2]
      end
    end
  end

  // acknowledge wins over a new edge: it both clears and blocks
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) latch_q <= 8'h00;
    else latch_q <= (latch_q | rise) & ~ack_q; // [R12]
  end

  // counters on channels 1 and 2, only during counter operation
  logic [15:0] cnt_val [2];
  for (genvar c = 0; c < 2; c++) begin : g_cnt
    dioc_counter u_cnt (
      .clk_in(REF_CLK_IN),
      .rst_n_in(rst_n),
      .enable_in(COUNTER_OP_IN),
      .sig_in(pin_q[c]),
      .cfg_in(ccfg_q[c]),
      .tb_in(tb),
      .value_out(cnt_val[c])
    );
  end

  // supply window check, reserved bits zero
  wire supply_bad = (SUPPLY_VOLT_IN < `DIOC_SUPPLY_LO) ||
                    (SUPPLY_VOLT_IN > `DIOC_SUPPLY_HI);

  // read mux, write-only and unmapped offsets read zero
  logic [15:0] rdata_d;
  always_comb begin
    rdata_d = 16'h0000;
    unique case (req.addr)
      `DIOC_OFS_INPUT: rdata_d[`DIOC_CAN_POS_INPUT +: 8] = state_q; // [R11]
      `DIOC_OFS_CNT1: rdata_d = cnt_val[0]; // [R14]
      `DIOC_OFS_CNT2: rdata_d = cnt_val[1]; // [R14]
      `DIOC_OFS_LATCH: rdata_d[7:0] = latch_q;
      `DIOC_OFS_FAULT: rdata_d[7:0] = fault_q;
      `DIOC_OFS_MODID: rdata_d = MODULE_ID;
      `DIOC_OFS_SUPST: rdata_d[0] = supply_bad;
      `DIOC_OFS_SUPIN: rdata_d[7:0] = SUPPLY_VOLT_IN;
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA_OUT <= 16'h0000;
      REG_ACK_OUT <= 1'b0;
    end else begin
      if (req.rd) REG_RDATA_OUT <= rdata_d;
      REG_ACK_OUT <= req.rd | req.wr;
    end
  end

  chk_dir_oe: assert property (@(posedge REF_CLK_IN) // [R1]
    disable iff (!rst_n) ##1 PIN_OE_OUT == $past(dir_q & ~lock))
    else $error("pin enable does not follow direction mask");
  chk_counter_lock: assert property (@(posedge REF_CLK_IN) // [R3]
    disable iff (!rst_n) COUNTER_OP_IN [*2] |-> PIN_OE_OUT[3:0] == 4'h0)
    else $error("counter pin driven in counter operation");
  chk_filter_sat: assert property (@(posedge REF_CLK_IN) // [R7]
    disable iff (!rst_n) filt_q > 8'd250 |-> filt_eff == 8'd250)
    else $error("filter value not clamped");
  chk_sample_grid: assert property (@(posedge REF_CLK_IN) // [R5]
    disable iff (!rst_n) sample |=> !sample [*8])
    else $error("samples too close together");
  chk_filter_off: assert property (@(posedge REF_CLK_IN) // [R6]
    disable iff (!rst_n) (sample && filt_eff == 8'h00) |=>
      state_q == $past(pin_q))
    else $error("unfiltered input not taken at sample");
  chk_out_bypass: assert property (@(posedge REF_CLK_IN) // [R2]
    disable iff (!rst_n) sample |=>
      ((state_q ^ $past(pin_q)) & $past(dir_eff)) == 8'h00)
    else $error("output channel went through filter");
  chk_latch_ack: assert property (@(posedge REF_CLK_IN) // [R12]
    disable iff (!rst_n) ##1 (latch_q & $past(ack_q)) == 8'h00)
    else $error("acknowledged latch still set");
  chk_fault_dir: assert property (@(posedge REF_CLK_IN) // [R13]
    disable iff (!rst_n) sample |=>
      fault_q == ($past(dir_eff) & ($past(pin_q) ^ $past(out_q))))
    else $error("fault status wrong");
  chk_sample_gap: assert property (@(posedge REF_CLK_IN) // [R5]
    disable iff (!rst_n) (sample && seen_q) |->
      gap_q == 16'(2 * TICK_CYCLES - 1))
    else $error("sample spacing wrong");
  chk_state_hold: assert property (@(posedge REF_CLK_IN) // [R5]
    disable iff (!rst_n) !sample |=> state_q == $past(state_q))
    else $error("input state changed off the sample grid");
  chk_fault_hold: assert property (@(posedge REF_CLK_IN) // [R13]
    disable iff (!rst_n) !sample |=> fault_q == $past(fault_q))
    else $error("fault status changed off the sample grid");
  chk_latch_edge: assert property (@(posedge REF_CLK_IN) // [R12]
    disable iff (!rst_n)
    ##1 ($past(rise) & ~$past(ack_q) & ~latch_q) == 8'h00)
    else $error("rising edge not latched");
  chk_latch_keep: assert property (@(posedge REF_CLK_IN) // [R12]
    disable iff (!rst_n)
    ##1 ($past(latch_q) & ~$past(ack_q) & ~latch_q) == 8'h00)
    else $error("latch dropped without acknowledge");
  chk_pin_drive: assert property (@(posedge REF_CLK_IN) // [R1]
    disable iff (!rst_n) ##1 PIN_OUT == $past(out_q & dir_eff))
    else $error("pin drive does not follow output command");
  chk_drive_oe: assert property (@(posedge REF_CLK_IN) // [R1]
    disable iff (!rst_n) (PIN_OUT & ~PIN_OE_OUT) == 8'h00)
    else $error("pin driven high while released");
  chk_counter_idle: assert property (@(posedge REF_CLK_IN) // [R14]
    disable iff (!rst_n) !COUNTER_OP_IN |=>
      (cnt_val[0] | cnt_val[1]) == 16'h0000)
    else $error("counter moved outside counter operation");
  chk_read_input: assert property (@(posedge REF_CLK_IN) // [R11]
    disable iff (!rst_n) (req.rd && req.addr == `DIOC_OFS_INPUT) |=>
      REG_RDATA_OUT == {8'h00, $past(state_q)})
    else $error("input state byte misplaced");
  chk_read_fault: assert property (@(posedge REF_CLK_IN) // [R13]
    disable iff (!rst_n) (req.rd && req.addr == `DIOC_OFS_FAULT) |=>
      REG_RDATA_OUT == {8'h00, $past(fault_q)})
    else $error("fault byte read wrong");
  chk_read_latch: assert property (@(posedge REF_CLK_IN) // [R12]
    disable iff (!rst_n) (req.rd && req.addr == `DIOC_OFS_LATCH) |=>
      REG_RDATA_OUT == {8'h00, $past(latch_q)})
    else $error("latch byte read wrong");
endmodule // dioc_top

// File: testbench/dioc_pin_model.sv
// pin-side model: loads the driven channels, can short any of them
`timescale 1ns/1ns
module dioc_pin_model (
  input wire logic [7:0] drv_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] ext_in,
  input wire logic [7:0] short_in,
  output logic [7:0] level_out
);
  // a shorted output reads back inverted, so the mismatch shows
  assign level_out = (oe_in & (drv_in ^ short_in)) | (~oe_in & ext_in);
endmodule // dioc_pin_model

// File: testbench/dioc_top_tb.sv
// self-checking bench of the i/o and counter block
`timescale 1ns/1ns
`include "dioc_cfg.svh"
module dioc_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cop = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [7:0] volt = 8'h18;
  logic [7:0] ext = 8'h00;
  logic [7:0] shrt = 8'h00;
  logic [15:0] v;
  wire [7:0] pin;
  wire [7:0] pout;
  wire [7:0] poe;
  wire [15:0] rdata;
  wire ack;
  int num_errors = 0;
  int total_checks = 0;

  always #4 clk = ~clk;

  // small tick keeps the sample grid at 16 cycles; id value is arbitrary
  dioc_top #(.TICK_CYCLES(8), .MODULE_ID(16'h3c5a)) i_dut (
    .REF_CLK_IN(clk),
    .RSTN_IN(rst_n),
    .COUNTER_OP_IN(cop),
    .PIN_IN(pin),
    .PIN_OUT(pout),
    .PIN_OE_OUT(poe),
    .SUPPLY_VOLT_IN(volt),
    .REG_WR_IN(wr),
    .REG_RD_IN(rd),
    .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata),
    .REG_RDATA_OUT(rdata),
    .REG_ACK_OUT(ack)
  );

  dioc_pin_model i_pins (
    .drv_in(pout),
    .oe_in(poe),
    .ext_in(ext),
    .short_in(shrt),
    .level_out(pin)
  );

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic bad(input string m);
    num_errors++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic ck(input logic [15:0] g, input logic [15:0] e,
                    input string m);
    total_checks++;
    if (g !== e) bad(m);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one strobe cycle, then a bounded wait for the acknowledge
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [15:0] d);
    int n;
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    // ack and read data are taken at the edge that samples ack high
    for (n = 0; n < 8; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      bad("no ack");
      complete_run();
    end
    v = rdata;
  endtask

  task automatic wreg(input logic [15:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rchk(input logic [15:0] a, input logic [15:0] e,
                      input string m);
    acc(1'b0, a, 16'h0000);
    ck(v, e, m);
  endtask

  task automatic pulse(input int b, input int n);
    repeat (n) begin
      ext[b] <= 1'b1;
      cyc(10);
      ext[b] <= 1'b0;
      cyc(10);
    end
  endtask

  task automatic t_reset();
    ck({8'h00, poe}, 16'h0000, "oe after reset");
    rchk(`DIOC_OFS_INPUT, 16'h0000, "input");
    rchk(`DIOC_OFS_DIR, 16'h0000, "write-only read");
    rchk(16'h0008, 16'h0000, "unmapped read");
    rchk(`DIOC_OFS_CNT1, 16'h0000, "counter reset");
    rchk(`DIOC_OFS_MODID, 16'h3c5a, "module id");
    rchk(`DIOC_OFS_SUPIN, 16'h0018, "supply volts");
    rchk(`DIOC_OFS_SUPST, 16'h0000, "supply in range");
    volt <= 8'h1f;
    cyc(3);
    rchk(`DIOC_OFS_SUPST, 16'h0001, "supply high");
    volt <= 8'h11;
    cyc(3);
    rchk(`DIOC_OFS_SUPST, 16'h0001, "supply low");
    volt <= 8'h18;
  endtask

  task automatic t_dir();
    wreg(`DIOC_OFS_DIR, 16'h00f5);
    wreg(`DIOC_OFS_OUTPUT, 16'h00ff);
    cyc(2);
    ck({8'h00, poe}, 16'h00f5, "enables");
    ck({8'h00, pout}, 16'h00f5, "drive");
    cop <= 1'b1;
    cyc(3);
    ck({8'h00, poe}, 16'h00f0, "counter op enables");
    cop <= 1'b0;
    shrt <= 8'h10;
    cyc(40);
    rchk(`DIOC_OFS_FAULT, 16'h0010, "fault set");
    shrt <= 8'h00;
    cyc(40);
    rchk(`DIOC_OFS_FAULT, 16'h0000, "fault gone");
    wreg(`DIOC_OFS_DIR, 16'h0000);
  endtask

  task automatic t_latch();
    // output readback in the last scenario left latches set
    wreg(`DIOC_OFS_ACK, 16'h00ff);
    wreg(`DIOC_OFS_ACK, 16'h0000);
    ext <= 8'h04;
    cyc(40);
    rchk(`DIOC_OFS_INPUT, 16'h0004, "input high");
    rchk(`DIOC_OFS_LATCH, 16'h0004, "edge latched");
    ext <= 8'h00;
    wreg(`DIOC_OFS_ACK, 16'h0004);
    cyc(40);
    rchk(`DIOC_OFS_LATCH, 16'h0000, "latch cleared");
    ext <= 8'h04;
    cyc(40);
    rchk(`DIOC_OFS_LATCH, 16'h0000, "latch blocked");
    ext <= 8'h00;
    wreg(`DIOC_OFS_ACK, 16'h0000);
    cyc(40);
    ext <= 8'h04;
    cyc(40);
    rchk(`DIOC_OFS_LATCH, 16'h0004, "latch again");
    ext <= 8'h00;
    wreg(`DIOC_OFS_ACK, 16'h0004);
    wreg(`DIOC_OFS_ACK, 16'h0000);
  endtask

  task automatic t_filter();
    wreg(`DIOC_OFS_FILT, 16'h0004);
    ext <= 8'h80;
    cyc(16);
    rchk(`DIOC_OFS_INPUT, 16'h0000, "filter early");
    cyc(60);
    rchk(`DIOC_OFS_INPUT, 16'h0080, "filter late");
    // 255 unclamped would take 2048 cycles, clamped 2000
    wreg(`DIOC_OFS_FILT, 16'h00ff);
    ext <= 8'h00;
    cyc(1960);
    rchk(`DIOC_OFS_INPUT, 16'h0080, "clamp early");
    cyc(70);
    rchk(`DIOC_OFS_INPUT, 16'h0000, "clamp late");
    wreg(`DIOC_OFS_FILT, 16'h0000);
  endtask

  task automatic gate(input logic [15:0] c, input int hi,
                      input int lo_e, input int hi_e);
    wreg(`DIOC_OFS_CCFG2, c);
    ext[1] <= 1'b1;
    cyc(hi);
    ext[1] <= 1'b0;
    cyc(8);
    acc(1'b0, `DIOC_OFS_CNT2, 16'h0000);
    total_checks++;
    if ((v >= lo_e && v <= hi_e) !== 1'b1) bad("gate time");
  endtask

  task automatic t_count();
    cop <= 1'b1;
    wreg(`DIOC_OFS_CCFG1, 16'h0000);
    pulse(0, 5);
    rchk(`DIOC_OFS_CNT1, 16'h0005, "events");
    wreg(`DIOC_OFS_CCFG1, 16'h0020);
    pulse(0, 3);
    rchk(`DIOC_OFS_CNT1, 16'h0000, "held clear");
    wreg(`DIOC_OFS_CCFG1, 16'h0000);
    pulse(0, 2);
    rchk(`DIOC_OFS_CNT1, 16'h0002, "resumed");
    gate(16'h0040, 1000, 382, 386);
    gate(16'h0041, 1000, 23, 25);
    gate(16'h0042, 2000, 2, 4);
    cop <= 1'b0;
  endtask

  initial begin
    cyc(3);
    rst_n <= 1'b1;
    cyc(3);
    t_reset();
    t_dir();
    t_latch();
    t_filter();
    t_count();
    complete_run();
  end
endmodule // dioc_top_tb
